// *** design/display_frame_fetch_dma.sv ***
// Frame-buffer fetch engine: APB registers, burst reader, pixel FIFO, unpacker.
// Assumes memory, display and APB all run on clk_i.
//
// Contract
// - After underflow both fetch pointers and FIFO pointers get reinitialised; the code reloads them only on fetch disable, frame end and power off.
// - Power off then on returns FIFO read and write pointers to zero.
// - Fetch disable then enable restarts fetching at the programmed start address.
// - No read burst crosses an aligned 1-Kbyte region.
// - Burst length in words is the burst field value plus one.
// - Packed mode takes 24-bit pixels contiguously across 32-bit words.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module display_frame_fetch_dma (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_b_i,
    // APB slave.
    input wire logic [frame_fetch_pkg::APB_AW-1:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [frame_fetch_pkg::DW-1:0] pwdata_i,
    output logic [frame_fetch_pkg::DW-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Memory read port.
    output logic mem_req_o,
    output logic [frame_fetch_pkg::DW-1:0] mem_addr_o,
    output logic [frame_fetch_pkg::LEN_W-1:0] mem_len_o,
    input wire logic mem_gnt_i,
    input wire logic mem_rvalid_i,
    input wire logic [frame_fetch_pkg::DW-1:0] mem_rdata_i,
    // Display pixel port.
    input wire logic pix_req_i,
    output logic pix_valid_o,
    output logic [frame_fetch_pkg::PIX_W-1:0] pix_data_o,
    // Interrupt.
    output logic irq_o
);
    import frame_fetch_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [DW-1:0] cfg_q, cfg_d;
    logic [DW-1:0] start_q, start_d;
    logic [EV_W-1:0] stat_q, stat_d;
    logic [EV_W-1:0] mask_q, mask_d;
    logic [DW-1:0] prdata_q, prdata_d;
    logic wr_en, hit, busy, power, fetch_en, pack24;
    logic ev_under, ev_done;

    assign power = ctrl_q[CTRL_POWER];
    assign fetch_en = ctrl_q[CTRL_FETCH];
    assign pack24 = ctrl_q[CTRL_PACK24];
    assign hit = (paddr_i == OFF_CTRL) || (paddr_i == OFF_CFG) || (paddr_i == OFF_START)
              || (paddr_i == OFF_STAT) || (paddr_i == OFF_MASK);
    assign wr_en = psel_i && penable_i && pwrite_i && hit;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;
    assign prdata_o = prdata_q;
    assign irq_o = |(stat_q & mask_q);

    always_comb
    begin
        ctrl_d = ctrl_q;
        cfg_d = cfg_q;
        start_d = start_q;
        mask_d = mask_q;
        stat_d = stat_q;
        prdata_d = prdata_q;
        if (wr_en)
        begin
            unique case (paddr_i)
                OFF_CTRL: ctrl_d = pwdata_i[CTRL_W-1:0];
                OFF_CFG: cfg_d = pwdata_i;
                OFF_START: start_d = pwdata_i;
                OFF_MASK: mask_d = pwdata_i[EV_W-1:0];
                OFF_STAT: stat_d = stat_q & ~pwdata_i[EV_W-1:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle.
        if (ev_under)
        begin
            stat_d[STAT_UNDER] = 1'b1;
        end
        if (ev_done)
        begin
            stat_d[STAT_DONE] = 1'b1;
        end
        // Read data is captured in the setup cycle and shown in the access phase.
        if (psel_i && !penable_i)
        begin
            prdata_d = '0;
            unique case (paddr_i)
                OFF_CTRL: prdata_d[CTRL_W-1:0] = ctrl_q;
                OFF_CFG: prdata_d = cfg_q;
                OFF_START: prdata_d = start_q;
                OFF_MASK: prdata_d[EV_W-1:0] = mask_q;
                OFF_STAT: prdata_d[STAT_BUSY:0] = {busy, stat_q};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            ctrl_q <= CTRL_RESET;
            cfg_q <= CFG_RESET;
            start_q <= START_RESET;
            stat_q <= EV_RESET;
            mask_q <= EV_RESET;
            prdata_q <= '0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            cfg_q <= cfg_d;
            start_q <= start_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            prdata_q <= prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst fetcher.
    fetch_state_t state_q, state_d;
    logic [DW-1:0] addr_q, addr_d;
    logic [CFG_LEN_W-1:0] left_q, left_d;
    logic [LEN_W-1:0] beat_q, beat_d;
    logic [CFG_LEN_W-1:0] burst_len, bound_len, blen;
    logic [FIFO_AW:0] wptr_q, wptr_d, rptr_q, rptr_d, level, free;
    logic fifo_we;

    assign busy = (state_q != ST_IDLE);
    assign level = wptr_q - rptr_q;
    assign free = FIFO_DEPTH - level;
    assign burst_len = CFG_LEN_W'(cfg_q[CFG_BURST_LSB +: CFG_BURST_W]) + 1'b1;
    assign bound_len = CFG_LEN_W'(REGION_WORDS - addr_q[REGION_AW-1:WORD_AW]);
    assign mem_req_o = (state_q == ST_REQ);
    assign mem_addr_o = addr_q;
    assign mem_len_o = beat_q;
    assign fifo_we = (state_q == ST_DATA) && mem_rvalid_i && power;

    always_comb
    begin
        state_d = state_q;
        addr_d = addr_q;
        left_d = left_q;
        beat_d = beat_q;
        ev_done = 1'b0;
        blen = burst_len;
        // Each burst ends at the burst length, the region edge or the frame end, whichever is first.
        if (bound_len < blen)
        begin
            blen = bound_len;
        end
        if (left_q < blen)
        begin
            blen = left_q;
        end
        unique case (state_q)
            ST_IDLE:
            begin
                if (!fetch_en)
                begin
                    addr_d = start_q;
                    left_d = cfg_q[CFG_LEN_LSB +: CFG_LEN_W];
                end
                else if (left_q == '0)
                begin
                    addr_d = start_q;
                    left_d = cfg_q[CFG_LEN_LSB +: CFG_LEN_W];
                    ev_done = 1'b1;
                end
                else if (power && (CFG_LEN_W'(free) >= blen))
                begin
                    beat_d = blen[LEN_W-1:0];
                    state_d = ST_REQ;
                end
            end
            ST_REQ:
            begin
                if (mem_gnt_i)
                begin
                    state_d = ST_DATA;
                end
            end
            ST_DATA:
            begin
                // A started burst always completes; busy covers it.
                if (mem_rvalid_i)
                begin
                    addr_d = addr_q + WORD_BYTES;
                    left_d = left_q - 1'b1;
                    beat_d = beat_q - 1'b1;
                    if (beat_q == LEN_W'(1))
                    begin
                        state_d = ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= ST_IDLE;
            addr_q <= START_RESET;
            left_q <= '0;
            beat_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            addr_q <= addr_d;
            left_q <= left_d;
            beat_q <= beat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pixel FIFO and unpacker. Power off holds every pointer at zero.
    logic [ACC_W-1:0] acc_q, acc_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, need;
    logic pend_q, pend_d, fifo_re, take;
    logic pix_valid_q, pix_valid_d;
    logic [PIX_W-1:0] pix_data_q, pix_data_d;
    logic [DW-1:0] fifo_rdata;

    assign need = pack24 ? BYTES_PIX24 : BYTES_WORD;
    assign fifo_re = power && (level != '0) && !pend_q && (cnt_q <= BYTES_WORD);
    assign take = power && pix_req_i && (cnt_q >= need);
    // Any request that goes unserved counts as an underflow, and that includes power off,
    // where the pointers are held at zero and the FIFO is empty by definition.
    assign ev_under = pix_req_i && !take;
    assign pix_valid_o = pix_valid_q;
    assign pix_data_o = pix_data_q;

    always_comb
    begin
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        acc_d = acc_q;
        cnt_d = cnt_q;
        pend_d = fifo_re;
        pix_valid_d = take;
        pix_data_d = pix_data_q;
        if (fifo_we)
        begin
            wptr_d = wptr_q + 1'b1;
        end
        if (fifo_re)
        begin
            rptr_d = rptr_q + 1'b1;
        end
        // Packed pixels straddle words, so bytes left over wait for the next word.
        if (take)
        begin
            pix_data_d = acc_q[PIX_W-1:0];
            acc_d = acc_q >> {need, 3'b000};
            cnt_d = cnt_q - need;
        end
        if (pend_q)
        begin
            acc_d = acc_d | ({{(ACC_W-DW){1'b0}}, fifo_rdata} << {cnt_d, 3'b000});
            cnt_d = cnt_d + BYTES_WORD;
        end
        if (!power)
        begin
            wptr_d = '0;
            rptr_d = '0;
            acc_d = '0;
            cnt_d = '0;
            pend_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
            acc_q <= '0;
            cnt_q <= '0;
            pend_q <= 1'b0;
            pix_valid_q <= 1'b0;
            pix_data_q <= '0;
        end
        else
        begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            pend_q <= pend_d;
            pix_valid_q <= pix_valid_d;
            pix_data_q <= pix_data_d;
        end
    end

    pixel_fifo_mem #(
        .AW(FIFO_AW),
        .DW(DW)
    ) u_fifo_mem (
        .clk_i(clk_i),
        .we_i(fifo_we),
        .waddr_i(wptr_q[FIFO_AW-1:0]),
        .wdata_i(mem_rdata_i),
        .re_i(fifo_re),
        .raddr_i(rptr_q[FIFO_AW-1:0]),
        .rdata_o(fifo_rdata)
    );

endmodule : display_frame_fetch_dma

`default_nettype wire

// *** shared/frame_fetch_pkg.sv ***
// Constants, register map and state encodings of the frame fetch engine.
// Assumes a single 25 MHz system clock and an APB register port.
package frame_fetch_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus widths.
    localparam int unsigned APB_AW = 12;
    localparam int unsigned DW = 32;
    localparam int unsigned PIX_W = 24;
    localparam int unsigned LEN_W = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [APB_AW-1:0] OFF_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] OFF_CFG = 12'h004;
    localparam logic [APB_AW-1:0] OFF_START = 12'h008;
    localparam logic [APB_AW-1:0] OFF_STAT = 12'h00c;
    localparam logic [APB_AW-1:0] OFF_MASK = 12'h010;

    // Control register bits.
    localparam int unsigned CTRL_W = 3;
    localparam int unsigned CTRL_POWER = 0;
    localparam int unsigned CTRL_FETCH = 1;
    localparam int unsigned CTRL_PACK24 = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

    // Frame fetch config register fields.
    localparam int unsigned CFG_BURST_LSB = 0;
    localparam int unsigned CFG_BURST_W = 4;
    localparam int unsigned CFG_LEN_LSB = 16;
    localparam int unsigned CFG_LEN_W = 16;
    localparam logic [DW-1:0] CFG_RESET = 32'h0000_000f;
    localparam logic [DW-1:0] START_RESET = 32'h0000_0000;

    // Status and mask layout; busy is read-only and not maskable.
    localparam int unsigned EV_W = 2;
    localparam int unsigned STAT_UNDER = 0;
    localparam int unsigned STAT_DONE = 1;
    localparam int unsigned STAT_BUSY = 2;
    localparam logic [EV_W-1:0] EV_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Memory region that no burst may cross, and word addressing.
    localparam int unsigned REGION_BYTES = 1024;
    localparam int unsigned REGION_AW = $clog2(REGION_BYTES);
    localparam int unsigned WORD_AW = 2;
    localparam logic [REGION_AW-WORD_AW:0] REGION_WORDS = 9'h100;
    localparam logic [DW-1:0] WORD_BYTES = 32'h0000_0004;

    // Pixel FIFO.
    localparam int unsigned FIFO_AW = 6;
    localparam logic [FIFO_AW:0] FIFO_DEPTH = 7'h40;

    // Unpacking accumulator, counted in bytes.
    localparam int unsigned ACC_W = 64;
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] BYTES_PIX24 = 4'h3;
    localparam logic [CNT_W-1:0] BYTES_WORD = 4'h4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_REQ = 3'b010,
        ST_DATA = 3'b100
    } fetch_state_t;

endpackage : frame_fetch_pkg

// *** design/pixel_fifo_mem.sv ***
// Simple dual-port storage of the pixel FIFO with registered read data.
// Assumes the caller keeps pointers and never writes a full array.
`timescale 1ns/100ps
`default_nettype none

module pixel_fifo_mem #(
    parameter int unsigned AW = 6,
    parameter int unsigned DW = 32
) (
    // Clock.
    input wire logic clk_i,
    // Write port.
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    // Read port.
    input wire logic re_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);

    logic [DW-1:0] mem_q [0:(1<<AW)-1];
    logic [DW-1:0] rdata_q;

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_q[waddr_i] <= wdata_i;
        end
        if (re_i)
        begin
            rdata_q <= mem_q[raddr_i];
        end
    end

    assign rdata_o = rdata_q;

endmodule : pixel_fifo_mem

`default_nettype wire

// *** tb/frame_fetch_asserts.sv ***
// Port checker of the frame fetch engine, bound to its top module.
// Assumes pready_o stays high, so an APB access phase lasts one cycle.
`timescale 1ns/100ps
`default_nettype none
module frame_fetch_asserts (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_b_i,
    // APB.
    input wire logic [frame_fetch_pkg::APB_AW-1:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [frame_fetch_pkg::DW-1:0] pwdata_i,
    // Memory, pixel and interrupt.
    input wire logic mem_req_o,
    input wire logic [frame_fetch_pkg::DW-1:0] mem_addr_o,
    input wire logic [frame_fetch_pkg::LEN_W-1:0] mem_len_o,
    input wire logic pix_req_i,
    input wire logic pix_valid_o,
    input wire logic irq_o
);
    import frame_fetch_pkg::*;
    logic wr;
    logic [3:0] burst_q, burst_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic [1:0] mask_q, mask_d;
    logic [31:0] start_q, start_d;
    logic restart_q, restart_d;
    // Shadow of the registers, and a flag armed by each fetch enable.
    always_comb
    begin
        wr = psel_i && penable_i && pwrite_i;
        burst_d = (wr && paddr_i == OFF_CFG) ? pwdata_i[3:0] : burst_q;
        ctrl_d = (wr && paddr_i == OFF_CTRL) ? pwdata_i[2:0] : ctrl_q;
        mask_d = (wr && paddr_i == OFF_MASK) ? pwdata_i[1:0] : mask_q;
        start_d = (wr && paddr_i == OFF_START) ? pwdata_i : start_q;
        restart_d = (restart_q && !mem_req_o) || (ctrl_d[1] && !ctrl_q[1]);
    end
    always_ff @(posedge clk_i)
        {burst_q, ctrl_q, mask_q, start_q, restart_q} <= rst_b_i ?
            {burst_d, ctrl_d, mask_d, start_d, restart_d} : {4'hf, 3'h0, 2'h0, 32'h0, 1'b0};
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    AST_BURST_REGION: assert property (
        mem_req_o |-> 10'(mem_addr_o[9:2]) + 10'(mem_len_o) <= 10'h100)
        else $error("burst crosses a 1 KB region");
    AST_BURST_LEN: assert property (
        mem_req_o |-> mem_len_o != 5'h0 && 5'(burst_q) + 5'h1 >= mem_len_o)
        else $error("burst length out of range");
    AST_PIX_CAUSE: assert property (
        pix_valid_o |-> $past(pix_req_i))
        else $error("pixel without request");
    AST_UNDER_IRQ: assert property (
        pix_req_i && mask_q[0] && !wr ##1 !pix_valid_o |-> irq_o)
        else $error("underflow raised no interrupt");
    AST_IRQ_MASK: assert property (
        irq_o |-> mask_q != 2'h0)
        else $error("interrupt while all masked");
    AST_POWER_EMPTY: assert property (
        !ctrl_q[0] && pix_req_i |=> !pix_valid_o)
        else $error("pixel served with power off");
    AST_FETCH_GATE: assert property (
        $rose(mem_req_o) |-> $past(ctrl_q[0]) && $past(ctrl_q[1]))
        else $error("burst while fetching off");
    AST_RESTART_ADDR: assert property (
        $rose(mem_req_o) && restart_q |-> mem_addr_o == start_q)
        else $error("restart not at start address");
endmodule : frame_fetch_asserts
bind display_frame_fetch_dma frame_fetch_asserts i_frame_fetch_asserts (.clk_i, .rst_b_i,
    .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .mem_req_o, .mem_addr_o,
    .mem_len_o, .pix_req_i, .pix_valid_o, .irq_o);
`default_nettype wire

// *** tb/frame_mem_model.sv ***
// Memory model answering burst reads with address-coded words.
// Assumes one burst at a time; slow_i delays grants and spaces beats.
`timescale 1ns/100ps
`default_nettype none
module frame_mem_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Burst port.
    input wire logic req_i,
    input wire logic [31:0] addr_i,
    input wire logic [4:0] len_i,
    input wire logic slow_i,
    output logic gnt_o = 1'b0,
    output logic rvalid_o = 1'b0,
    output logic [31:0] rdata_o = 32'h5a5a_0f0f
);
    logic [31:0] a;
    int left = 0;
    int t = 0;
    // Idle data toggles so a stale word is never mistaken for a beat.
    always @(posedge clk_i)
    begin
        gnt_o <= 1'b0;
        rvalid_o <= 1'b0;
        rdata_o <= ~rdata_o;
        t <= t + 1;
        if (!rst_b_i)
            left <= 0;
        else if (left == 0 && req_i && !gnt_o && (!slow_i || t[1:0] == 2'h3))
        begin
            gnt_o <= 1'b1;
            a <= addr_i;
            left <= len_i;
        end
        else if (left != 0 && (!slow_i || t[0]))
        begin
            rvalid_o <= 1'b1;
            rdata_o <= {a[7:0] + 8'h3, a[7:0] + 8'h2, a[7:0] + 8'h1, a[7:0]};
            a <= a + 32'h4;
            left <= left - 1;
        end
    end
endmodule : frame_mem_model
`default_nettype wire

// *** tb/display_frame_fetch_dma_tb_top.sv ***
// Self-checking bench of the frame fetch engine against the memory model.
// Assumes the port checker is bound from its own file.
`timescale 1ns/100ps
`default_nettype none
module display_frame_fetch_dma_tb_top;
    import frame_fetch_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic pix_req_i = 1'b0;
    logic slow = 1'b0;
    logic [APB_AW-1:0] paddr_i = '0;
    logic [DW-1:0] pwdata_i = '0;
    logic [DW-1:0] prdata_o, mem_addr_o, mem_rdata_i, r;
    logic pready_o, pslverr_o, mem_req_o, mem_gnt_i, mem_rvalid_i, pix_valid_o, irq_o, e;
    logic [LEN_W-1:0] mem_len_o;
    logic [PIX_W-1:0] pix_data_o;
    logic [31:0] seed = 32'h06d01f5d;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int idx = 0;
    int nreq = 0;
    int nval = 0;
    int start, bpp, fbytes, b;
    int tab [4][4] = '{'{0, 15, 32'h3c0, 20}, '{1, 3, 32'h30, 12}, '{1, 15, 32'hc0, 24},
        '{0, 3, 32'h3f0, 8}};
    logic [11:0] offs [6] = '{OFF_CTRL, OFF_CFG, OFF_START, OFF_STAT, OFF_MASK, 12'h014};
    logic [31:0] rst_val [6] = '{32'h0, CFG_RESET, START_RESET, 32'h0, 32'h0, 32'h0};
    display_frame_fetch_dma i_display_frame_fetch_dma (.clk_i, .rst_b_i, .paddr_i, .psel_i,
        .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mem_req_o,
        .mem_addr_o, .mem_len_o, .mem_gnt_i, .mem_rvalid_i, .mem_rdata_i, .pix_req_i,
        .pix_valid_o, .pix_data_o, .irq_o);
    frame_mem_model i_frame_mem_model (.clk_i, .rst_b_i, .req_i(mem_req_o),
        .addr_i(mem_addr_o), .len_i(mem_len_o), .slow_i(slow), .gnt_o(mem_gnt_i),
        .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
    always #20 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic stream(input int n);
        repeat (80) @(posedge clk_i);
        for (int k = 0; k < n; k++)
        begin
            pix_req_i <= 1'b1;
            nreq++;
            @(posedge clk_i);
            pix_req_i <= 1'b0;
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
            repeat (2 + int'(seed[2:0])) @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
    endtask : stream
    // Underflow recovery; one request with power off must go unserved.
    task automatic recover;
        apb(1'b1, OFF_CTRL, 32'h2);
        pix_req_i <= 1'b1;
        @(posedge clk_i);
        pix_req_i <= 1'b0;
        apb(1'b1, OFF_CTRL, 32'h0);
        do apb(1'b0, OFF_STAT, 32'h0); while (r[STAT_BUSY] !== 1'b0);
        chk("underflow", 32'h1, {31'h0, r[STAT_UNDER]});
        chk("irq set", 32'h1, {31'h0, irq_o});
        apb(1'b1, OFF_MASK, 32'h0);
        @(posedge clk_i);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        apb(1'b1, OFF_STAT, 32'h3);
        apb(1'b1, OFF_MASK, 32'h1);
        @(posedge clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
    endtask : recover
    task automatic complete_run;
        if (num_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            complete_run();
        end
        if (pix_valid_o === 1'b1)
        begin
            b = start + (idx * bpp) % fbytes;
            chk("pixel", {8'h0, 8'(b + 2), 8'(b + 1), 8'(b)}, {8'h0, pix_data_o});
            idx++;
            nval++;
        end
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int k = 0; k < 6; k++)
        begin
            apb(1'b0, offs[k], 32'h0);
            chk("reset value", rst_val[k], r);
            chk("slave error", 32'(k == 5), {31'h0, e});
        end
        apb(1'b1, OFF_MASK, 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            recover();
            apb(1'b1, OFF_CFG, {16'(tab[k][3]), 12'h0, 4'(tab[k][1])});
            apb(1'b1, OFF_START, 32'(tab[k][2]));
            apb(1'b1, OFF_CTRL, 32'(tab[k][0] * 4 + 1));
            start = tab[k][2];
            bpp = 4 - tab[k][0];
            fbytes = 4 * tab[k][3];
            idx = 0;
            nreq = 0;
            nval = 0;
            slow <= k[0];
            apb(1'b1, OFF_CTRL, 32'(tab[k][0] * 4 + 3));
            stream(2 * fbytes / bpp);
            chk("served", 32'(nreq), 32'(nval));
        end
        complete_run();
    end
endmodule : display_frame_fetch_dma_tb_top
`default_nettype wire
